// ---- src/srm_pkg.sv ----
// Constants, types and decode helpers of the sync reference monitor
`default_nettype none
package srm_pkg;

  // Delay taps on the sync reference pin, one sample per tap per clock edge
  localparam int SRM_TAPS = 6;
  localparam int SRM_WINDOWS = 5;
  // Tap k samples the pin at (SRM_TAP_FIRST_PS + k * SRM_TAP_STEP_PS)
  localparam int SRM_TAP_FIRST_PS = -60;
  localparam int SRM_TAP_STEP_PS = 40;
  localparam int SRM_WINDOW_LAST_PS = 140;
  // The functional capture sits 60 ps after the sampling edge
  localparam int SRM_CAPTURE_DELAY_PS = 60;
  localparam int SRM_TAP_CAPTURE =
    (SRM_CAPTURE_DELAY_PS - SRM_TAP_FIRST_PS) / SRM_TAP_STEP_PS;

  // Serial programming frame: 1 direction bit, 3 spare, 12 address, 8 data
  localparam int SRM_ADDR_W = 12;
  localparam int SRM_DATA_W = 8;
  localparam int SRM_FRAME_BITS = 24;
  localparam int SRM_HDR_BITS = 16;
  localparam int SRM_CNT_W = 5;
  localparam logic [SRM_CNT_W-1:0] SRM_HDR_LAST = 5'h0F;
  localparam logic [SRM_CNT_W-1:0] SRM_FRAME_LAST = 5'h17;
  localparam int SRM_RW_POS = 23;
  localparam int SRM_ADDR_LSB = 8;
  localparam int SRM_HDR_RW_POS = 15;

  // Register offsets
  localparam logic [SRM_ADDR_W-1:0] SRM_ADDR_STATUS = 12'h140;
  localparam logic [SRM_ADDR_W-1:0] SRM_ADDR_PIN_CFG = 12'h146;
  localparam logic [SRM_ADDR_W-1:0] SRM_ADDR_SYNC_MASK = 12'h147;
  localparam logic [SRM_ADDR_W-1:0] SRM_ADDR_MODE = 12'h148;

  // Reset values and field encodings
  localparam logic [SRM_DATA_W-1:0] SRM_PIN_CFG_RST = 8'h01;
  localparam logic [SRM_DATA_W-1:0] SRM_PIN_SYNC_SEL = 8'h00;
  localparam logic [SRM_DATA_W-1:0] SRM_SYNC_MASK_RST = 8'h00;
  localparam logic [SRM_DATA_W-1:0] SRM_MODE_RST = 8'h00;

  // Status bits
  localparam int SRM_STAT_SEEN = 6;
  localparam int SRM_STAT_ANY = 5;
  // Mask bits: a set bit keeps that block out of the sync reset
  localparam int SRM_MASK_DIV = 0;
  localparam int SRM_MASK_OSC = 1;
  localparam int SRM_MASK_RAMP = 2;
  // Mode bit: set selects down-conversion, clear selects bypass
  localparam int SRM_MODE_DDC = 0;

  typedef enum logic [1:0] {
    SRM_IDLE,
    SRM_HEADER,
    SRM_DATA,
    SRM_DONE
  } srm_spi_state_t;

  function automatic logic srm_hit(input logic [SRM_ADDR_W-1:0] addr,
                                   input logic [SRM_ADDR_W-1:0] offs);
    return addr == offs;
  endfunction

endpackage
`default_nettype wire

// ---- src/srm_win_if.sv ----
// Signals between the window detector and the register side
`timescale 1ns/1ps
`default_nettype none
interface srm_win_if;
  import srm_pkg::*;
  logic [SRM_TAPS-1:0] taps;
  logic enable;
  logic edge_stb;
  logic [SRM_WINDOWS-1:0] flags;
  logic any;
  modport det (input taps, input enable,
               output edge_stb, output flags, output any);
  modport ctl (output taps, output enable,
               input edge_stb, input flags, input any);
endinterface
`default_nettype wire

// ---- src/srm_window_detect.sv ----
// Sync edge capture and timing window classification
`timescale 1ns/1ps
`default_nettype none
module srm_window_detect
  import srm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  srm_win_if.det win
);

  logic [SRM_TAPS-1:0] tap_r;
  logic [SRM_TAPS-1:0] tap_prev_r;
  logic level_prev_r;
  logic edge_stb_r;
  logic [SRM_WINDOWS-1:0] flags_r;
  logic any_r;
  logic [SRM_WINDOWS-1:0] win_xor;
  logic rise;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tap_r <= '0;
      tap_prev_r <= '0;
      level_prev_r <= 1'b0;
    end else begin
      tap_r <= win.taps;
      tap_prev_r <= tap_r;
      level_prev_r <= tap_r[SRM_TAP_CAPTURE];
    end
  end

  // A transition between two neighbouring taps marks its window. An edge
  // later than the capture tap was seen one clock before the capture tap
  // registers it, so the late windows look one sample back.
  for (genvar g = 0; g < SRM_WINDOWS; g++) begin : g_xor
    if (g < SRM_TAP_CAPTURE) begin : g_now
      assign win_xor[g] = tap_r[g] ^ tap_r[g+1];
    end else begin : g_back
      assign win_xor[g] = tap_prev_r[g] ^ tap_prev_r[g+1];
    end
  end

  // Only the delayed capture tap decides an edge; the others only grade it
  assign rise = win.enable && tap_r[SRM_TAP_CAPTURE] && !level_prev_r;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      edge_stb_r <= 1'b0;
      flags_r <= '0;
      any_r <= 1'b0;
    end else begin
      edge_stb_r <= rise;
      if (rise) begin
        flags_r <= win_xor;
        any_r <= |win_xor;
      end
    end
  end

  assign win.edge_stb = edge_stb_r;
  assign win.flags = flags_r;
  assign win.any = any_r;

  property p_capture;
    @(posedge clk_in) disable iff (!rstn_in)
      rise |=> edge_stb_r && flags_r == $past(win_xor);
  endproperty
  a_capture: assert property (p_capture)
    else $error("window flags not refreshed on sync edge");

  property p_routed;
    @(posedge clk_in) disable iff (!rstn_in)
      !win.enable |=> !edge_stb_r;
  endproperty
  a_routed: assert property (p_routed)
    else $error("sync edge taken while pin not routed");

  property p_window_one;
    @(posedge clk_in) disable iff (!rstn_in)
      rise && !tap_r[0] && tap_r[1] |=> flags_r[0] && any_r;
  endproperty
  a_window_one: assert property (p_window_one)
    else $error("early edge did not raise window one");

  property p_window_five;
    @(posedge clk_in) disable iff (!rstn_in)
      rise && (tap_prev_r[SRM_WINDOWS-1] != tap_prev_r[SRM_WINDOWS]) |=>
        flags_r[SRM_WINDOWS-1];
  endproperty
  a_window_five: assert property (p_window_five)
    else $error("late edge did not raise window five");

endmodule // srm_window_detect
`default_nettype wire

// ---- src/srm_top.sv ----
// Sync reference monitor with serial register port
`timescale 1ns/1ps
`default_nettype none
module srm_top
  import srm_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [SRM_TAPS-1:0] GENERAL_PIN_ZERO_TAPS_IN,
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_SEN_N_IN,
  input wire logic SPI_SDIO_IN,
  output logic SPI_SDIO_OUT,
  output logic SPI_SDIO_OE_OUT,
  output logic DIVIDER_RESET_OUT,
  output logic OSC_PHASE_RESET_OUT,
  output logic RAMP_RESTART_OUT
);

  srm_win_if win ();

  srm_window_detect u_detect (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .win(win)
  );

  // Serial port state
  srm_spi_state_t state_r;
  logic sclk_prev_r;
  logic [SRM_CNT_W-1:0] bit_cnt_r;
  logic [SRM_FRAME_BITS-1:0] shift_r;
  logic [SRM_DATA_W-1:0] rd_shift_r;
  logic rd_active_r;
  logic sdio_r;
  logic sdio_oe_r;
  logic wr_stb_r;
  logic [SRM_ADDR_W-1:0] wr_addr_r;
  logic [SRM_DATA_W-1:0] wr_data_r;

  // Registers
  logic [SRM_DATA_W-1:0] pin_cfg_r;
  logic [SRM_DATA_W-1:0] sync_mask_r;
  logic [SRM_DATA_W-1:0] mode_r;
  logic seen_r;

  // Sync actions
  logic div_rst_r;
  logic osc_rst_r;
  logic ramp_rst_r;

  logic sclk_rise;
  logic sclk_fall;
  logic [SRM_FRAME_BITS-1:0] shift_nxt;
  logic [SRM_ADDR_W-1:0] hdr_addr;
  logic [SRM_DATA_W-1:0] rd_data;
  logic seen_clr;

  // SCLK is slow against the reference clock, so it is edge detected here
  assign sclk_rise = SPI_SCLK_IN && !sclk_prev_r;
  assign sclk_fall = !SPI_SCLK_IN && sclk_prev_r;
  assign shift_nxt = {shift_r[SRM_FRAME_BITS-2:0], SPI_SDIO_IN};
  assign hdr_addr = shift_nxt[SRM_ADDR_W-1:0];

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= SPI_SCLK_IN;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      state_r <= SRM_IDLE;
      bit_cnt_r <= '0;
      shift_r <= '0;
    end else if (SPI_SEN_N_IN) begin
      state_r <= SRM_IDLE;
      bit_cnt_r <= '0;
    end else begin
      unique case (state_r)
        SRM_IDLE: begin
          state_r <= SRM_HEADER;
          bit_cnt_r <= '0;
        end
        SRM_HEADER: begin
          if (sclk_rise) begin
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == SRM_HDR_LAST) begin
              state_r <= SRM_DATA;
            end
          end
        end
        SRM_DATA: begin
          if (sclk_rise) begin
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == SRM_FRAME_LAST) begin
              state_r <= SRM_DONE;
            end
          end
        end
        SRM_DONE: begin
          state_r <= SRM_DONE;
        end
      endcase
    end
  end

  // Write strobe once the last data bit of a write frame is in
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      wr_stb_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
    end else begin
      wr_stb_r <= 1'b0;
      if (!SPI_SEN_N_IN && state_r == SRM_DATA && sclk_rise &&
          bit_cnt_r == SRM_FRAME_LAST) begin
        wr_stb_r <= !shift_nxt[SRM_RW_POS];
        wr_addr_r <= shift_nxt[SRM_ADDR_LSB +: SRM_ADDR_W];
        wr_data_r <= shift_nxt[SRM_DATA_W-1:0];
      end
    end
  end

  always_comb begin
    rd_data = '0;
    if (srm_hit(hdr_addr, SRM_ADDR_STATUS)) begin
      rd_data[SRM_STAT_SEEN] = seen_r;
      rd_data[SRM_STAT_ANY] = win.any;
      rd_data[SRM_WINDOWS-1:0] = win.flags;
    end else if (srm_hit(hdr_addr, SRM_ADDR_PIN_CFG)) begin
      rd_data = pin_cfg_r;
    end else if (srm_hit(hdr_addr, SRM_ADDR_SYNC_MASK)) begin
      rd_data = sync_mask_r;
    end else if (srm_hit(hdr_addr, SRM_ADDR_MODE)) begin
      rd_data = mode_r;
    end
  end

  // Read data leaves on SCLK falling edges, MSB first, after the header
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      rd_shift_r <= '0;
      rd_active_r <= 1'b0;
      sdio_r <= 1'b0;
      sdio_oe_r <= 1'b0;
    end else if (SPI_SEN_N_IN) begin
      rd_active_r <= 1'b0;
      sdio_oe_r <= 1'b0;
      sdio_r <= 1'b0;
    end else begin
      if (state_r == SRM_HEADER && sclk_rise && bit_cnt_r == SRM_HDR_LAST &&
          shift_nxt[SRM_HDR_RW_POS]) begin
        rd_shift_r <= rd_data;
        rd_active_r <= 1'b1;
      end else if (rd_active_r && sclk_fall && state_r == SRM_DATA) begin
        sdio_oe_r <= 1'b1;
        sdio_r <= rd_shift_r[SRM_DATA_W-1];
        rd_shift_r <= {rd_shift_r[SRM_DATA_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      pin_cfg_r <= SRM_PIN_CFG_RST;
      sync_mask_r <= SRM_SYNC_MASK_RST;
      mode_r <= SRM_MODE_RST;
    end else if (wr_stb_r) begin
      if (srm_hit(wr_addr_r, SRM_ADDR_PIN_CFG)) begin
        pin_cfg_r <= wr_data_r;
      end
      if (srm_hit(wr_addr_r, SRM_ADDR_SYNC_MASK)) begin
        sync_mask_r <= wr_data_r;
      end
      if (srm_hit(wr_addr_r, SRM_ADDR_MODE)) begin
        mode_r <= wr_data_r;
      end
    end
  end

  // Writing a one to D6 of the status clears the seen bit; a new edge wins
  assign seen_clr = wr_stb_r && srm_hit(wr_addr_r, SRM_ADDR_STATUS) &&
                    wr_data_r[SRM_STAT_SEEN];

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      seen_r <= 1'b0;
    end else if (win.edge_stb) begin
      seen_r <= 1'b1;
    end else if (seen_clr) begin
      seen_r <= 1'b0;
    end
  end

  // Only a routed pin feeds the detector
  assign win.taps = GENERAL_PIN_ZERO_TAPS_IN;
  assign win.enable = (pin_cfg_r == SRM_PIN_SYNC_SEL);

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      div_rst_r <= 1'b0;
      osc_rst_r <= 1'b0;
      ramp_rst_r <= 1'b0;
    end else begin
      div_rst_r <= win.edge_stb && mode_r[SRM_MODE_DDC] &&
                   !sync_mask_r[SRM_MASK_DIV];
      osc_rst_r <= win.edge_stb && mode_r[SRM_MODE_DDC] &&
                   !sync_mask_r[SRM_MASK_OSC];
      // Bypass latency is fixed already; only the ramp needs realigning
      ramp_rst_r <= win.edge_stb && !mode_r[SRM_MODE_DDC] &&
                    !sync_mask_r[SRM_MASK_RAMP];
    end
  end

  assign SPI_SDIO_OUT = sdio_r;
  assign SPI_SDIO_OE_OUT = sdio_oe_r;
  assign DIVIDER_RESET_OUT = div_rst_r;
  assign OSC_PHASE_RESET_OUT = osc_rst_r;
  assign RAMP_RESTART_OUT = ramp_rst_r;

  property p_div_reset;
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      win.edge_stb && mode_r[SRM_MODE_DDC] && !sync_mask_r[SRM_MASK_DIV]
        |=> DIVIDER_RESET_OUT ##1 !DIVIDER_RESET_OUT || win.edge_stb;
  endproperty
  a_div_reset: assert property (p_div_reset)
    else $error("divider reset missing after sync edge");

  property p_bypass_quiet;
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      DIVIDER_RESET_OUT || OSC_PHASE_RESET_OUT |->
        $past(mode_r[SRM_MODE_DDC]) && $past(win.edge_stb);
  endproperty
  a_bypass_quiet: assert property (p_bypass_quiet)
    else $error("decimation reset without sync edge in ddc mode");

  property p_osc_mask;
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      win.edge_stb && sync_mask_r[SRM_MASK_OSC] |=> !OSC_PHASE_RESET_OUT;
  endproperty
  a_osc_mask: assert property (p_osc_mask)
    else $error("masked oscillator phase was reset");

  property p_ramp;
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      win.edge_stb && !mode_r[SRM_MODE_DDC] && !sync_mask_r[SRM_MASK_RAMP]
        |=> RAMP_RESTART_OUT && !DIVIDER_RESET_OUT;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp not restarted in bypass mode");

  property p_seen_sticky;
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      seen_r && !seen_clr |=> seen_r;
  endproperty
  a_seen_sticky: assert property (p_seen_sticky)
    else $error("seen bit dropped without a clear");

  property p_seen_set;
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      win.edge_stb |=> seen_r;
  endproperty
  a_seen_set: assert property (p_seen_set)
    else $error("seen bit not set by sync edge");

  property p_any;
    @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      win.edge_stb |-> win.any == (|win.flags);
  endproperty
  a_any: assert property (p_any)
    else $error("summary bit disagrees with window flags");

endmodule // srm_top
`default_nettype wire

// ---- verif/srm_sync_source.sv ----
// Behavioural sync reference source driving the delayed pin samples
`timescale 1ns/1ps
`default_nettype none
module srm_sync_source (
  input wire logic clk_in,
  input wire logic fire_in,
  input wire logic [2:0] window_in,
  input wire logic [3:0] hold_in,
  output logic [5:0] taps_out
);
  logic pend_r;
  logic [3:0] cnt_r;
  initial begin
    taps_out = 6'h00;
    cnt_r = 4'h0;
    pend_r = 1'b0;
  end
  // Request taken on the rising edge so the pin moves only on falling edges
  always @(posedge clk_in) pend_r <= fire_in;
  // One pulse per request, high for hold_in cycles, then low again
  always @(negedge clk_in) begin
    if (pend_r && cnt_r == 4'h0) begin
      // Window 0 puts the edge on the clock falling edge
      taps_out <= 6'h3F << window_in;
      cnt_r <= hold_in;
    end else if (cnt_r > 4'h1) begin
      taps_out <= 6'h3F;
      cnt_r <= cnt_r - 4'h1;
    end else begin
      taps_out <= 6'h00;
      cnt_r <= 4'h0;
    end
  end
endmodule // srm_sync_source
`default_nettype wire

// ---- verif/srm_top_test.sv ----
// Self-checking bench for the sync reference monitor
`timescale 1ns/1ps
`default_nettype none
module srm_top_test;
  import srm_pkg::*;
  logic clk, rstn, sclk, sen_n, sdio, fire, routed, rd_stb;
  logic sdio_out, sdio_oe, div_p, osc_p, ramp_p;
  logic [2:0] win, w;
  logic [3:0] hold;
  logic [5:0] taps;
  logic [7:0] rd_cap, mode, mask;
  logic [2:0] exp_p[$];
  logic [7:0] exp_r[$];
  int miscompares, total_checks;

  srm_top dut (.REF_CLK_IN(clk), .RSTN_IN(rstn),
    .GENERAL_PIN_ZERO_TAPS_IN(taps), .SPI_SCLK_IN(sclk),
    .SPI_SEN_N_IN(sen_n), .SPI_SDIO_IN(sdio), .SPI_SDIO_OUT(sdio_out),
    .SPI_SDIO_OE_OUT(sdio_oe), .DIVIDER_RESET_OUT(div_p),
    .OSC_PHASE_RESET_OUT(osc_p), .RAMP_RESTART_OUT(ramp_p));
  srm_sync_source src (.clk_in(clk), .fire_in(fire), .window_in(win),
    .hold_in(hold), .taps_out(taps));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic fail(input string msg);
    miscompares++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask

  task automatic report_and_stop();
    if (exp_p.size() != 0 || exp_r.size() != 0) fail("result missing");
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Results are compared in the order they were promised
  always @(posedge clk) begin
    if (rd_stb) begin
      total_checks++;
      if (exp_r.size() == 0 || rd_cap !== exp_r[0]) fail("read data");
      if (exp_r.size() != 0) void'(exp_r.pop_front());
    end
    if ({ramp_p, osc_p, div_p} !== 3'h0) begin
      total_checks++;
      if (exp_p.size() == 0 || {ramp_p, osc_p, div_p} !== exp_p[0])
        fail("action pulse");
      if (exp_p.size() != 0) void'(exp_p.pop_front());
    end
  end

  // SCLK held low 3 cycles and high 4 since the port oversamples it
  task automatic spi(input logic rd, input logic [11:0] a,
                     input logic [7:0] d, input int nb);
    logic [23:0] fr;
    fr = {rd, 3'h0, a, d};
    @(negedge clk);
    sen_n = 1'b0;
    for (int i = 23; i >= 24 - nb; i--) begin
      @(negedge clk);
      sclk = 1'b0;
      sdio = (rd && i < 8) ? ~sdio : fr[i];
      repeat (3) @(negedge clk);
      if (rd && i < 8) rd_cap[i] = sdio_out;
      if (rd && i == 0) begin
        total_checks++;
        if (sdio_oe !== 1'b1) fail("output enable");
      end
      sclk = 1'b1;
      repeat (3) @(negedge clk);
    end
    @(negedge clk);
    sclk = 1'b0;
    repeat (2) @(negedge clk);
    sen_n = 1'b1;
    rd_stb = rd && nb == 24;
    @(negedge clk);
    rd_stb = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_r.push_back(e);
    spi(1'b1, a, 8'h00, 24);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    spi(1'b0, a, d, 24);
  endtask

  task automatic sync(input logic [2:0] wi);
    logic [2:0] p;
    p = mode[0] ? {1'b0, ~mask[1], ~mask[0]} : {~mask[2], 2'b00};
    if (routed && p != 3'h0) exp_p.push_back(p);
    @(negedge clk);
    win = wi;
    hold = 4'($urandom_range(2, 9));
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    repeat (14) @(negedge clk);
  endtask

  function automatic logic [7:0] stat(input logic [2:0] wi,
                                      input logic seen);
    logic [4:0] f;
    f = (wi == 3'h0) ? 5'h00 : 5'(5'h01 << (wi - 3'h1));
    return {1'b0, seen, |f, f};
  endfunction

  initial begin
    repeat (40000) @(posedge clk);
    fail("timeout");
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    sclk = 1'b0;
    sen_n = 1'b1;
    sdio = 1'b0;
    fire = 1'b0;
    win = 3'h0;
    hold = 4'h2;
    rd_stb = 1'b0;
    routed = 1'b0;
    mode = 8'h00;
    mask = 8'h00;
    rd_cap = 8'h00;
    miscompares = 0;
    total_checks = 0;
    void'($urandom(27018));
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd(SRM_ADDR_STATUS, 8'h00);
    rd(SRM_ADDR_PIN_CFG, SRM_PIN_CFG_RST);
    rd(SRM_ADDR_MODE, SRM_MODE_RST);
    wr(12'h145, 8'hFF);
    rd(12'h145, 8'h00);
    // Pin not yet routed: the edge must leave no trace
    sync(3'h2);
    rd(SRM_ADDR_STATUS, 8'h00);
    wr(SRM_ADDR_PIN_CFG, SRM_PIN_SYNC_SEL);
    rd(SRM_ADDR_PIN_CFG, SRM_PIN_SYNC_SEL);
    routed = 1'b1;
    wr(SRM_ADDR_MODE, 8'h01);
    mode = 8'h01;
    for (int i = 0; i <= 5; i++) begin
      w = 3'(i);
      sync(w);
      rd(SRM_ADDR_STATUS, stat(w, 1'b1));
      wr(SRM_ADDR_STATUS, 8'h40);
      rd(SRM_ADDR_STATUS, stat(w, 1'b0));
    end
    // A frame cut short by SEN must not write
    spi(1'b0, SRM_ADDR_MODE, 8'h00, 20);
    rd(SRM_ADDR_MODE, 8'h01);
    wr(SRM_ADDR_MODE, 8'h00);
    mode = 8'h00;
    sync(3'h4);
    rd(SRM_ADDR_STATUS, stat(3'h4, 1'b1));
    for (int i = 0; i < 8; i++) begin
      mode = 8'($urandom_range(0, 1));
      mask = 8'($urandom_range(0, 7));
      w = 3'($urandom_range(0, 5));
      wr(SRM_ADDR_MODE, mode);
      wr(SRM_ADDR_SYNC_MASK, mask);
      rd(SRM_ADDR_SYNC_MASK, mask);
      sync(w);
      wr(SRM_ADDR_STATUS, 8'hBF);
      rd(SRM_ADDR_STATUS, stat(w, 1'b1));
    end
    repeat (10) @(negedge clk);
    report_and_stop();
  end
endmodule // srm_top_test
`default_nettype wire
